//--- dpf_pkg.sv
/*
 Package for the dual-port buffer: register map, flag layout, reset values, modes.
 Assumes a 32-bit Avalon-MM slave with word addressing by byte address / 4.
*/
package dpf_pkg;
   localparam int DEPTH_DEF = 16;
   localparam int WIDTH_DEF = 5;
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_LEVEL = 8'h08;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h0c;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h10;
   localparam logic [7:0] OFF_WDATA = 8'h14;
   localparam logic [7:0] OFF_RDATA = 8'h18;
   localparam int FLAG_FULL = 0;
   localparam int FLAG_EMPTY = 1;
   localparam int FLAG_NEAR_FULL = 2;
   localparam int FLAG_NEAR_EMPTY = 3;
   localparam int FLAG_ALMOST = 4;
   localparam int FLAG_HALF = 5;
   localparam int FLAG_WR_REFUSED = 6;
   localparam int FLAG_RD_REFUSED = 7;
   localparam int NUM_FLAGS = 8;
   localparam logic [1:0] CTRL_RESET = 2'h0;
   localparam logic [7:0] MASK_RESET = 8'h00;
   localparam logic [31:0] BAD_ADDR_DATA = 32'h0000_0000;
   localparam int ALMOST_OFFSET = 2;
   typedef enum logic {DPF_ORG_POINTER, DPF_ORG_CHAIN} dpf_org_t;
   typedef enum logic {DPF_OFFSET_TWO, DPF_OFFSET_ONE} dpf_offset_t;
endpackage

//--- dpf_mem_if.sv
/*
 Interface carrying the write and read ports between the buffer control and its storage.
 Assumes a single clock; the storage answers reads one cycle later.
*/
`timescale 1ns/1ps
`default_nettype none
interface dpf_mem_if #(parameter int WIDTH = 5, parameter int AW = 4);
   logic wr_en;
   logic [AW-1:0] wr_addr;
   logic [WIDTH-1:0] wr_data;
   logic [AW-1:0] rd_addr;
   logic [WIDTH-1:0] rd_data;
   modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
   modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface
`default_nettype wire

//--- dpf_ram.sv
/*
 Dual-port storage: one write port, one registered read port.
 Assumes the controller never writes a slot the reader is draining.
*/
`timescale 1ns/1ps
`default_nettype none
module dpf_ram #(parameter int WIDTH = 5, parameter int AW = 4)
(
   input wire logic ref_clk,
   dpf_mem_if.mem port
);
   logic [WIDTH-1:0] store [0:(1<<AW)-1];
   logic [WIDTH-1:0] rd_data_reg;
   always_ff @(posedge ref_clk)
   begin
      if (port.wr_en)
      begin
         store[port.wr_addr] <= port.wr_data;
      end
      rd_data_reg <= store[port.rd_addr];
   end
   assign port.rd_data = rd_data_reg;
endmodule // dpf_ram
`default_nettype wire

//--- dpf_fifo.sv
/*
 Dual-port first-in first-out buffer with a pointer RAM form and a shifting chain form,
 status flags, sticky events with mask and one level interrupt, Avalon-MM registers.
 Assumes producer and consumer logic sit on ref_clk; software may also push and pop.
*/
`timescale 1ns/1ps
`default_nettype none
module dpf_fifo #(
   parameter int WIDTH = dpf_pkg::WIDTH_DEF,
   parameter int DEPTH = dpf_pkg::DEPTH_DEF,
   parameter dpf_pkg::dpf_org_t ORG = dpf_pkg::DPF_ORG_POINTER
)
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic wr_req,
   input wire logic [WIDTH-1:0] wr_data,
   output logic wr_ready,
   input wire logic rd_req,
   output logic [WIDTH-1:0] rd_data,
   output logic rd_valid,
   output logic flag_full,
   output logic flag_empty,
   output logic flag_near_full,
   output logic flag_near_empty,
   output logic flag_almost,
   output logic flag_half,
   output logic irq,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
   localparam logic [AW:0] HALF_C = (AW+1)'(DEPTH / 2);
   localparam logic [AW:0] ONE_C = (AW+1)'(1);
   localparam logic [AW:0] TWO_C = (AW+1)'(dpf_pkg::ALMOST_OFFSET);

   logic [AW-1:0] wptr_reg;
   logic [AW-1:0] rptr_reg;
   logic [AW:0] count_reg;
   logic [1:0] ctrl_reg;
   logic [7:0] irq_stat_reg;
   logic [7:0] irq_mask_reg;
   logic [7:0] flags_prev_reg;
   logic [WIDTH-1:0] rd_data_reg;
   logic rd_valid_reg;
   logic ack_reg;
   logic [31:0] avs_readdata_reg;
   logic [WIDTH-1:0] bus_wdata_reg;
   logic bus_push_reg;
   logic bus_pop_reg;

   // Bus decode
   wire [7:0] byte_addr = {1'b0, avs_address, 2'b00};
   wire bus_cycle = (avs_read | avs_write) & ~ack_reg;
   wire hit_ctrl = byte_addr == dpf_pkg::OFF_CTRL;
   wire hit_status = byte_addr == dpf_pkg::OFF_STATUS;
   wire hit_level = byte_addr == dpf_pkg::OFF_LEVEL;
   wire hit_istat = byte_addr == dpf_pkg::OFF_IRQ_STAT;
   wire hit_imask = byte_addr == dpf_pkg::OFF_IRQ_MASK;
   wire hit_wdata = byte_addr == dpf_pkg::OFF_WDATA;
   wire hit_rdata = byte_addr == dpf_pkg::OFF_RDATA;
   wire bus_wr = bus_cycle & avs_write;
   wire bus_rd = bus_cycle & avs_read;
   wire sw_enable = ctrl_reg[0];
   wire offset_one = ctrl_reg[1];

   // Software push and pop share the ports; the producer and consumer pins win.
   wire push_any = wr_req | bus_push_reg;
   wire [WIDTH-1:0] push_data = wr_req ? wr_data : bus_wdata_reg;
   wire pop_any = rd_req | bus_pop_reg;
   wire full_w = count_reg == DEPTH_C;
   wire empty_w = count_reg == '0;
   wire do_wr = push_any & ~full_w & sw_enable;
   wire do_rd = pop_any & ~empty_w & sw_enable;
   wire wr_refused = push_any & ~do_wr;
   wire rd_refused = pop_any & ~do_rd;

   // Offset flags
   wire [AW:0] near_gap = offset_one ? ONE_C : TWO_C;
   wire near_full_w = count_reg >= DEPTH_C - near_gap;
   wire near_empty_w = count_reg <= near_gap;
   wire almost_w = near_full_w | near_empty_w;
   wire half_w = count_reg >= HALF_C;
   wire [7:0] flags_now = {rd_refused, wr_refused, half_w, almost_w,
                           near_empty_w, near_full_w, empty_w, full_w};
   wire [7:0] flag_rise = flags_now & ~flags_prev_reg;
   wire [7:0] istat_clr = (bus_wr & hit_istat) ? avs_writedata[7:0] : 8'h00;
   wire [7:0] irq_stat_next = (irq_stat_reg & ~istat_clr) | flag_rise;
   wire [WIDTH-1:0] head_data;

   assign wr_ready = ~full_w & sw_enable;
   assign flag_full = full_w;
   assign flag_empty = empty_w;
   assign flag_near_full = near_full_w;
   assign flag_near_empty = near_empty_w;
   assign flag_almost = almost_w;
   assign flag_half = half_w;
   assign irq = |(irq_stat_reg & irq_mask_reg);
   assign rd_data = rd_data_reg;
   assign rd_valid = rd_valid_reg;
   assign avs_readdata = avs_readdata_reg;
   assign avs_waitrequest = bus_cycle;

   generate
      if (ORG == dpf_pkg::DPF_ORG_POINTER)
      begin : g_ram
         dpf_mem_if #(.WIDTH(WIDTH), .AW(AW)) mem_bus ();
         assign mem_bus.wr_en = do_wr;
         assign mem_bus.wr_addr = wptr_reg;
         assign mem_bus.wr_data = push_data;
         // Read address looks ahead so the head word sits ready: fall-through in one cycle
         assign mem_bus.rd_addr = do_rd ? AW'(rptr_reg + 1'b1) : rptr_reg;
         dpf_ram #(.WIDTH(WIDTH), .AW(AW)) u_ram
         (
            .ref_clk(ref_clk),
            .port(mem_bus.mem)
         );
         // Bypass covers a write into the slot the read side is about to show
         logic byp_reg;
         logic [WIDTH-1:0] byp_data_reg;
         always_ff @(posedge ref_clk or posedge rst)
         begin
            if (rst)
            begin
               byp_reg <= 1'b0;
               byp_data_reg <= '0;
            end
            else
            begin
               byp_reg <= do_wr & (wptr_reg == mem_bus.rd_addr);
               byp_data_reg <= push_data;
            end
         end
         assign head_data = byp_reg ? byp_data_reg : mem_bus.rd_data;
      end
      else
      begin : g_chain
         // Stages packed toward the output; stage 0 is the output end
         logic [WIDTH-1:0] stage_reg [0:DEPTH-1];
         for (genvar i = 0; i < DEPTH; i++)
         begin : g_stage
            wire [AW:0] idx = (AW+1)'(i);
            wire [AW:0] fill_at = do_rd ? count_reg - ONE_C : count_reg;
            always_ff @(posedge ref_clk)
            begin
               if (do_wr & (idx == fill_at))
               begin
                  stage_reg[i] <= push_data;
               end
               else if (do_rd && i < DEPTH - 1)
               begin
                  stage_reg[i] <= stage_reg[i+1];
               end
            end
         end
         assign head_data = stage_reg[0];
      end
   endgenerate

   // Pointers and fill count
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         wptr_reg <= '0;
         rptr_reg <= '0;
         count_reg <= '0;
      end
      else
      begin
         if (do_wr)
         begin
            wptr_reg <= (wptr_reg == AW'(DEPTH - 1)) ? '0 : AW'(wptr_reg + 1'b1);
         end
         if (do_rd)
         begin
            rptr_reg <= (rptr_reg == AW'(DEPTH - 1)) ? '0 : AW'(rptr_reg + 1'b1);
         end
         count_reg <= count_reg + (AW+1)'(do_wr) - (AW+1)'(do_rd);
      end
   end

   // Read port: data of a taken read appear one cycle later
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         rd_data_reg <= '0;
         rd_valid_reg <= 1'b0;
      end
      else
      begin
         rd_valid_reg <= do_rd;
         if (do_rd)
         begin
            rd_data_reg <= head_data;
         end
      end
   end

   // Registers, events and bus handshake
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         ctrl_reg <= dpf_pkg::CTRL_RESET;
         irq_mask_reg <= dpf_pkg::MASK_RESET;
         irq_stat_reg <= '0;
         flags_prev_reg <= '0;
         ack_reg <= 1'b0;
         avs_readdata_reg <= '0;
         bus_wdata_reg <= '0;
         bus_push_reg <= 1'b0;
         bus_pop_reg <= 1'b0;
      end
      else
      begin
         ack_reg <= bus_cycle;
         flags_prev_reg <= flags_now;
         // Set wins over a clear in the same cycle
         irq_stat_reg <= irq_stat_next;
         bus_push_reg <= bus_wr & hit_wdata;
         bus_pop_reg <= bus_rd & hit_rdata;
         if (bus_wr & hit_wdata)
         begin
            bus_wdata_reg <= avs_writedata[WIDTH-1:0];
         end
         if (bus_wr & hit_ctrl)
         begin
            ctrl_reg <= avs_writedata[1:0];
         end
         if (bus_wr & hit_imask)
         begin
            irq_mask_reg <= avs_writedata[7:0];
         end
         if (bus_rd)
         begin
            avs_readdata_reg <= hit_ctrl ? {30'h0, ctrl_reg} :
                                hit_status ? {24'h0, flags_now} :
                                hit_level ? 32'((count_reg)) :
                                hit_istat ? {24'h0, irq_stat_reg} :
                                hit_imask ? {24'h0, irq_mask_reg} :
                                hit_rdata ? 32'(head_data) | {31'h0, empty_w} << 31 :
                                dpf_pkg::BAD_ADDR_DATA;
         end
      end
   end
endmodule // dpf_fifo
`default_nettype wire

//--- dpf_fifo_monitor.sv
/*
 Checker for the buffer's flags, push and pop handshakes and bus wait state.
 Assumes it is bound to dpf_fifo and sees only that module's ports.
*/
`timescale 1ns/1ps
`default_nettype none
module dpf_fifo_monitor #(parameter int WIDTH = 5, parameter int DEPTH = 16)
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic wr_req,
   input wire logic wr_ready,
   input wire logic rd_req,
   input wire logic rd_valid,
   input wire logic flag_full,
   input wire logic flag_empty,
   input wire logic flag_near_full,
   input wire logic flag_near_empty,
   input wire logic flag_almost,
   input wire logic flag_half,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // Enable bit is not a port, so wr_ready stands in for it
   sequence s_push;
      wr_req && wr_ready;
   endsequence
   sequence s_pop;
      rd_req && !flag_empty && wr_ready;
   endsequence
   a_full_stops_push: assert property (flag_full |-> !wr_ready)
      else $error("push offered while full");
   a_no_underrun: assert property (rd_valid |-> !$past(flag_empty))
      else $error("word delivered from empty buffer");
   a_pop_answer: assert property (s_pop |=> rd_valid)
      else $error("taken pop gave no word");
   a_push_visible: assert property (s_push and flag_empty |=> !flag_empty)
      else $error("word not visible one cycle after push");
   a_full_holds: assert property (flag_full && !rd_req && !avs_read |=> flag_full)
      else $error("full buffer changed without a pop");
   a_empty_flags: assert property (flag_empty |-> flag_near_empty && !flag_half)
      else $error("empty buffer flags wrong");
   a_full_flags: assert property (flag_full |-> flag_near_full && flag_half)
      else $error("full buffer flags wrong");
   a_almost_or: assert property (flag_almost == (flag_near_full || flag_near_empty))
      else $error("almost flag not the or of offsets");
   a_reset_clear: assert property ($fell(rst) |-> flag_empty && !rd_valid)
      else $error("buffer not empty after reset");
   a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus access not answered in one cycle");
endmodule // dpf_fifo_monitor
bind dpf_fifo dpf_fifo_monitor #(.WIDTH(WIDTH), .DEPTH(DEPTH)) mon_u (.ref_clk, .rst, .wr_req,
   .wr_ready, .rd_req, .rd_valid, .flag_full, .flag_empty, .flag_near_full, .flag_near_empty,
   .flag_almost, .flag_half, .avs_read, .avs_write, .avs_waitrequest);
`default_nettype wire

//--- dpf_peer.sv
/*
 Producer and consumer logic at the buffer's pin ports.
 Assumes the bench opens each request for whole cycles on ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module dpf_peer #(parameter int WIDTH = 5)
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic go_push,
   input wire logic go_pop,
   input wire logic wr_ready,
   input wire logic rd_valid,
   output logic wr_req,
   output logic [WIDTH-1:0] wr_data,
   output logic rd_req,
   output logic [WIDTH-1:0] exp_data
);
   assign wr_req = go_push;
   assign rd_req = go_pop;
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         wr_data <= '0;
         exp_data <= '0;
      end
      else
      begin
         // Only taken words advance, so a refused push leaves no gap
         if (wr_req && wr_ready)
            wr_data <= wr_data + 1'b1;
         if (rd_valid)
            exp_data <= exp_data + 1'b1;
      end
   end
endmodule // dpf_peer
`default_nettype wire

//--- test_dual_port_fifo_buffer.sv
/*
 Self-checking bench: flag table by level, refusals, interrupt, reset, fall-through.
 Assumes dpf_fifo with pointer form, depth 16, width 5.
*/
`timescale 1ns/1ps
`default_nettype none
module test_dual_port_fifo_buffer;
   typedef struct packed {logic [1:0] ctrl; logic [4:0] lvl; logic [5:0] flg;} dpf_row_t;
   localparam int DEPTH = 16;
   logic ref_clk = 1'b0, rst = 1'b1, go_push = 1'b0, go_pop = 1'b0;
   logic avs_read = 1'b0, avs_write = 1'b0, wr_req, wr_ready, rd_req, rd_valid, irq;
   logic flag_full, flag_empty, flag_near_full, flag_near_empty, flag_almost, flag_half;
   logic avs_waitrequest;
   logic [4:0] avs_address = 5'h00, wr_data, rd_data, exp_data;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, rdv;
   logic [5:0] flg;
   int error_cnt = 0, checked = 0, lvl = 0;
   // Fill then drain, so each flag is seen both rising and falling
   dpf_row_t rows [12] = '{'{2'h1, 5'h00, 6'h16}, '{2'h1, 5'h01, 6'h06}, '{2'h1, 5'h02, 6'h06},
      '{2'h1, 5'h03, 6'h00}, '{2'h1, 5'h08, 6'h01}, '{2'h1, 5'h0e, 6'h0b}, '{2'h1, 5'h10, 6'h2b},
      '{2'h3, 5'h0f, 6'h0b}, '{2'h3, 5'h0e, 6'h01}, '{2'h3, 5'h02, 6'h00}, '{2'h3, 5'h01, 6'h06},
      '{2'h3, 5'h00, 6'h16}};
   assign flg = {flag_full, flag_empty, flag_near_full, flag_near_empty, flag_almost, flag_half};
   dpf_fifo #(.WIDTH(5), .DEPTH(DEPTH)) dut_u (.ref_clk, .rst, .wr_req, .wr_data, .wr_ready,
      .rd_req, .rd_data, .rd_valid, .flag_full, .flag_empty, .flag_near_full, .flag_near_empty,
      .flag_almost, .flag_half, .irq, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_readdata, .avs_waitrequest);
   dpf_peer #(.WIDTH(5)) peer_u (.ref_clk, .rst, .go_push, .go_pop, .wr_ready, .rd_valid,
      .wr_req, .wr_data, .rd_req, .exp_data);
   initial
   begin
      forever #5 ref_clk = ~ref_clk;
   end
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e)
      begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // Waits on waitrequest with a bound; a stuck slave ends the run
   task automatic bus(input logic we, input logic [7:0] off, input logic [31:0] wd,
      output logic [31:0] rd);
      int n;
      n = 0;
      @(posedge ref_clk);
      avs_read <= !we;
      avs_write <= we;
      avs_address <= off[6:2];
      avs_writedata <= wd;
      do
      begin
         @(negedge ref_clk);
         n++;
      end
      while (avs_waitrequest !== 1'b0 && n < 20);
      if (n == 20)
      begin
         error_cnt++;
         give_verdict();
      end
      else
      begin
         rd = avs_readdata;
         @(posedge ref_clk);
         avs_read <= 1'b0;
         avs_write <= 1'b0;
      end
   endtask
   task automatic rd_chk(input string nm, input logic [7:0] off, input logic [31:0] e);
      bus(1'b0, off, 32'h0, rdv);
      chk(nm, rdv, e);
   endtask
   task automatic xfer(input logic p, input logic q);
      logic v;
      v = q && lvl > 0;
      @(posedge ref_clk);
      go_push <= p;
      go_pop <= q;
      @(posedge ref_clk);
      go_push <= 1'b0;
      go_pop <= 1'b0;
      @(negedge ref_clk);
      chk("rd_valid", rd_valid, v);
      if (v)
         chk("rd_data", rd_data, exp_data);
      lvl = lvl + int'(p && lvl < DEPTH) - int'(v);
   endtask
   initial
   begin
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      @(negedge ref_clk);
      chk("flags reset", flg, 6'h16);
      rd_chk("mask reset", dpf_pkg::OFF_IRQ_MASK, 32'h0);
      rd_chk("unmapped", 8'h7c, 32'h0);
      foreach (rows[i])
      begin
         bus(1'b1, dpf_pkg::OFF_CTRL, 32'(rows[i].ctrl), rdv);
         while (lvl < rows[i].lvl) xfer(1'b1, 1'b0);
         while (lvl > rows[i].lvl) xfer(1'b0, 1'b1);
         @(negedge ref_clk);
         chk("flags", flg, rows[i].flg);
         rd_chk("level", dpf_pkg::OFF_LEVEL, lvl);
      end
      $display("flag table done");
      xfer(1'b0, 1'b1);
      while (lvl < DEPTH) xfer(1'b1, 1'b0);
      xfer(1'b1, 1'b0);
      chk("ready full", wr_ready, 1'b0);
      rd_chk("level full", dpf_pkg::OFF_LEVEL, 32'd16);
      xfer(1'b0, 1'b1);
      $display("refusal test done");
      bus(1'b1, dpf_pkg::OFF_IRQ_MASK, 32'hc0, rdv);
      @(negedge ref_clk);
      chk("irq set", irq, 1'b1);
      rd_chk("events", dpf_pkg::OFF_IRQ_STAT, 32'hff);
      bus(1'b1, dpf_pkg::OFF_IRQ_STAT, 32'hff, rdv);
      @(negedge ref_clk);
      chk("irq clear", irq, 1'b0);
      rd_chk("mask", dpf_pkg::OFF_IRQ_MASK, 32'hc0);
      $display("interrupt test done");
      xfer(1'b1, 1'b1);
      rd_chk("level both", dpf_pkg::OFF_LEVEL, lvl);
      rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      lvl = 0;
      @(negedge ref_clk);
      chk("flags mid reset", flg, 6'h16);
      rd_chk("level reset", dpf_pkg::OFF_LEVEL, 32'h0);
      bus(1'b1, dpf_pkg::OFF_CTRL, 32'h1, rdv);
      @(posedge ref_clk);
      go_push <= 1'b1;
      @(posedge ref_clk);
      go_push <= 1'b0;
      go_pop <= 1'b1;
      @(posedge ref_clk);
      go_pop <= 1'b0;
      @(negedge ref_clk);
      chk("fall valid", rd_valid, 1'b1);
      chk("fall data", rd_data, exp_data);
      bus(1'b1, dpf_pkg::OFF_WDATA, 32'h15, rdv);
      rd_chk("bus pop", dpf_pkg::OFF_RDATA, 32'h15);
      rd_chk("level bus", dpf_pkg::OFF_LEVEL, 32'h0);
      $display("reset and fall-through done");
      give_verdict();
   end
endmodule // test_dual_port_fifo_buffer
`default_nettype wire
